/* src/smbtr_pkg.sv */
package smbtr_pkg;

  // Clock and timing
  localparam int CLK_PERIOD_NS    = 10;
  localparam int HOLD_TIMEOUT_MS  = 37;
  localparam int HOLD_TIMEOUT_CYC = HOLD_TIMEOUT_MS * 1000000 / CLK_PERIOD_NS;
  localparam int HOLD_CNT_W       = 22;
  localparam int SCL_PERIOD_NS    = 1000;
  localparam int SCL_QUARTER_CYC  = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
  localparam int TICK_CNT_W       = 8;

  // Addresses; the device address value is arbitrary
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2A;
  localparam logic [6:0] ARA_ADDR         = 7'h0C;

  // Register file
  localparam int         REG_NUM   = 16;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [7:0] REG_CH1   = 8'h01;
  localparam logic [7:0] REG_LOCAL = 8'h07;
  localparam logic [7:0] REG_EXT   = 8'h09;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [2:0] CH1_CHAN  = 3'h1;
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // Result codes
  localparam logic [7:0] TEMP_MAX_BYTE = 8'h7F;
  localparam logic [7:0] TEMP_MIN_BYTE = 8'h00;
  localparam logic [7:0] FAULT_OPEN    = 8'hFF;
  localparam logic [7:0] FAULT_SHORT   = 8'hEE;
  localparam logic [7:0] EXT_FAULT     = 8'h00;
  localparam logic [1:0] FLT_NONE      = 2'h0;
  localparam logic [1:0] FLT_OPEN      = 2'h1;
  localparam logic [1:0] FLT_SHORT     = 2'h2;

  // Transaction kinds offered to the host user
  typedef enum logic [3:0] {
    KIND_WRITE = 4'h1,
    KIND_READ  = 4'h2,
    KIND_SEND  = 4'h4,
    KIND_RECV  = 4'h8
  } smbtr_kind_type;

  // Host bus elements
  typedef enum logic [2:0] {
    E_START = 3'h0,
    E_WADDR = 3'h1,
    E_WCMD  = 3'h2,
    E_WDATA = 3'h3,
    E_RADDR = 3'h4,
    E_READ  = 3'h5,
    E_STOP  = 3'h6,
    E_DONE  = 3'h7
  } smbtr_elem_type;

endpackage

/* src/smbtr_if.sv */
`timescale 1ns/10ps
interface smbtr_if;
  logic scl;
  logic host_sda_o;
  logic host_sda_oe_n;
  logic dev_sda_o;
  logic dev_sda_oe_n;
  logic sda;

  // Pulled-up data line, low while either end drives a zero
  assign sda = (host_sda_oe_n | host_sda_o) & (dev_sda_oe_n | dev_sda_o);

  modport host (output scl, output host_sda_o, output host_sda_oe_n, input sda);
  modport dev  (input scl, input sda, output dev_sda_o, output dev_sda_oe_n);
endinterface

/* src/smbtr_dev.sv */
`timescale 1ns/10ps
module smbtr_dev
  import smbtr_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT,
  parameter int         HOLD_CYC = HOLD_TIMEOUT_CYC
)
(
  smbtr_if.dev              bus,         // Two-wire link
  input  wire logic         clock,       // System clock
  input  wire logic         arst_n,      // Async reset
  input  wire logic         conv_valid,  // New conversion result
  input  wire logic [2:0]   conv_chan,   // Channel 1..6, 7 local
  input  wire logic [11:0]  conv_temp,   // Signed, eighths of a degree
  input  wire logic [1:0]   conv_fault,  // Diode fault code
  input  wire logic         alert_req,   // Alert pending
  output logic              alert_done,  // Alert response done pulse
  output logic              wr_strobe,   // Register written pulse
  output logic [7:0]        wr_index,    // Written register
  output logic [7:0]        wr_data,     // Written value
  output logic              hold_active  // Channel 1 high byte frozen
);

  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_RX    = 5'h02,
    ST_ACK   = 5'h04,
    ST_TX    = 5'h08,
    ST_TXACK = 5'h10
  } smbtr_dev_state_type;

  localparam logic [HOLD_CNT_W-1:0] HOLD_LOAD = HOLD_CNT_W'(HOLD_CYC - 1);

  // Main byte: whole degrees with clamping and fault codes
  function automatic logic [7:0] high_byte(input logic [11:0] t, input logic [1:0] f);
    if (f == FLT_OPEN)
      return FAULT_OPEN;
    else if (f == FLT_SHORT)
      return FAULT_SHORT;
    else if (t[11])
      return TEMP_MIN_BYTE;
    else if (t[10])
      return TEMP_MAX_BYTE;
    else
      return {1'b0, t[9:3]};
  endfunction

  // Extended byte: fraction in the top three bits
  function automatic logic [7:0] ext_byte(input logic [11:0] t, input logic [1:0] f);
    if (f != FLT_NONE)
      return EXT_FAULT;
    else
      return {t[2:0], 5'h00};
  endfunction

  logic [1:0]              scl_sync_reg, scl_sync_next;
  logic [1:0]              sda_sync_reg, sda_sync_next;
  logic                    scl_d_reg, scl_d_next;
  logic                    sda_d_reg, sda_d_next;
  smbtr_dev_state_type     state_reg, state_next;
  logic [3:0]              bitcnt_reg, bitcnt_next;
  logic [1:0]              idx_reg, idx_next;
  logic [7:0]              shift_reg, shift_next;
  logic [7:0]              tx_reg, tx_next;
  logic                    rw_reg, rw_next;
  logic                    ara_reg, ara_next;
  logic [7:0]              ptr_reg, ptr_next;
  logic [7:0]              regs_reg [0:REG_NUM-1];
  logic [7:0]              regs_next [0:REG_NUM-1];
  logic                    hold_reg, hold_next;
  logic [HOLD_CNT_W-1:0]   hold_cnt_reg, hold_cnt_next;
  logic                    sda_oe_n_reg, sda_oe_n_next;
  logic                    done_reg, done_next;
  logic                    wr_stb_reg, wr_stb_next;
  logic [7:0]              wr_idx_reg, wr_idx_next;
  logic [7:0]              wr_dat_reg, wr_dat_next;
  logic                    scl_now, sda_now;
  logic                    scl_rise, scl_fall, start_cond, stop_cond;
  logic                    ptr_in_map, ptr_writable;
  logic [7:0]              read_data;

  // Link synchronisers and delayed copies
  always_comb
  begin
    scl_sync_next = {scl_sync_reg[0], bus.scl};
    sda_sync_next = {sda_sync_reg[0], bus.sda};
    scl_d_next    = scl_sync_reg[1];
    sda_d_next    = sda_sync_reg[1];
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      scl_d_reg    <= 1'b1;
      sda_d_reg    <= 1'b1;
    end
    else
    begin
      scl_sync_reg <= scl_sync_next;
      sda_sync_reg <= sda_sync_next;
      scl_d_reg    <= scl_d_next;
      sda_d_reg    <= sda_d_next;
    end
  end

  // Bus events
  assign scl_now    = scl_sync_reg[1];
  assign sda_now    = sda_sync_reg[1];
  assign scl_rise   = scl_now & ~scl_d_reg;
  assign scl_fall   = ~scl_now & scl_d_reg;
  assign start_cond = scl_now & scl_d_reg & sda_d_reg & ~sda_now;
  assign stop_cond  = scl_now & scl_d_reg & ~sda_d_reg & sda_now;

  // Register map decode
  // byte-wide map
  assign ptr_in_map   = (ptr_reg < 8'(REG_NUM));
  assign ptr_writable = ptr_in_map && (ptr_reg != REG_EXT)
                        && ((ptr_reg < REG_CH1) || (ptr_reg > REG_LOCAL));
  assign read_data    = ptr_in_map ? regs_reg[ptr_reg[3:0]] : REG_RESET;

  // Slave protocol, result capture and hold timer
  always_comb
  begin
    state_next    = state_reg;
    bitcnt_next   = bitcnt_reg;
    idx_next      = idx_reg;
    shift_next    = shift_reg;
    tx_next       = tx_reg;
    rw_next       = rw_reg;
    ara_next      = ara_reg;
    ptr_next      = ptr_reg;
    regs_next     = regs_reg;
    hold_next     = hold_reg;
    hold_cnt_next = hold_cnt_reg;
    done_next     = 1'b0;
    wr_stb_next   = 1'b0;
    wr_idx_next   = wr_idx_reg;
    wr_dat_next   = wr_dat_reg;
    if (conv_valid && (conv_chan != 3'h0) && !(hold_reg && (conv_chan == CH1_CHAN)))
    begin
      regs_next[{1'b0, conv_chan}] = high_byte(conv_temp, conv_fault);
      if (conv_chan == CH1_CHAN)
        regs_next[REG_EXT[3:0]] = ext_byte(conv_temp, conv_fault);
    end
    if (hold_reg)
    begin
      if (hold_cnt_reg == '0)
        hold_next = 1'b0;
      else
        hold_cnt_next = hold_cnt_reg - 1'b1;
    end
    case (state_reg)
      ST_IDLE:
      begin
        state_next = ST_IDLE;
      end
      ST_RX:
      begin
        if (scl_rise)
        begin
          shift_next  = {shift_reg[6:0], sda_now};
          bitcnt_next = bitcnt_reg + 4'h1;
        end
        else if (scl_fall && (bitcnt_reg == BYTE_BITS))
        begin
          bitcnt_next = 4'h0;
          state_next  = ST_ACK;
          case (idx_reg)
            2'h0:
            begin
              if (shift_reg[7:1] == DEV_ADDR)
              begin
                rw_next  = shift_reg[0];
                ara_next = 1'b0;
              end
              else if ((shift_reg == {ARA_ADDR, 1'b1}) && alert_req)
              begin
                rw_next  = 1'b1;
                ara_next = 1'b1;
              end
              else
                state_next = ST_IDLE;
            end
            2'h1: ptr_next = shift_reg;
            2'h2:
            begin
              if (ptr_writable)
                regs_next[ptr_reg[3:0]] = shift_reg;
              wr_stb_next = ptr_writable;
              wr_idx_next = ptr_reg;
              wr_dat_next = shift_reg;
            end
            default: state_next = ST_IDLE;
          endcase
        end
      end
      ST_ACK:
      begin
        if (scl_fall)
        begin
          bitcnt_next = 4'h0;
          if (rw_reg)
          begin
            state_next = ST_TX;
            if (ara_reg)
              tx_next = {DEV_ADDR, 1'b1};
            else
            begin
              tx_next = read_data;
              if (ptr_reg == REG_EXT)
              begin
                hold_next     = 1'b1;
                hold_cnt_next = HOLD_LOAD;
              end
              else if (ptr_reg == REG_CH1)
                hold_next = 1'b0;
            end
          end
          else
          begin
            state_next = ST_RX;
            idx_next   = idx_reg + 2'h1;
          end
        end
      end
      ST_TX:
      begin
        if (scl_rise)
        begin
          // Lost alert arbitration releases the line
          if (ara_reg && tx_reg[7] && !sda_now)
            state_next = ST_IDLE;
          bitcnt_next = bitcnt_reg + 4'h1;
        end
        else if (scl_fall)
        begin
          if (bitcnt_reg == BYTE_BITS)
            state_next = ST_TXACK;
          else
            tx_next = {tx_reg[6:0], 1'b1};
        end
      end
      ST_TXACK:
      begin
        if (scl_rise)
        begin
          state_next = ST_IDLE;
          done_next  = ara_reg;
        end
      end
      default: state_next = ST_IDLE;
    endcase
    if (stop_cond)
      state_next = ST_IDLE;
    if (start_cond)
    begin
      state_next  = ST_RX;
      bitcnt_next = 4'h0;
      idx_next    = 2'h0;
    end
    sda_oe_n_next = !((state_next == ST_ACK) || ((state_next == ST_TX) && !tx_next[7]));
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_reg    <= ST_IDLE;
      bitcnt_reg   <= 4'h0;
      idx_reg      <= 2'h0;
      shift_reg    <= 8'h00;
      tx_reg       <= 8'hFF;
      rw_reg       <= 1'b0;
      ara_reg      <= 1'b0;
      ptr_reg      <= PTR_RESET;
      for (int i = 0; i < REG_NUM; i++)
        regs_reg[i] <= REG_RESET;
      hold_reg     <= 1'b0;
      hold_cnt_reg <= '0;
      sda_oe_n_reg <= 1'b1;
      done_reg     <= 1'b0;
      wr_stb_reg   <= 1'b0;
      wr_idx_reg   <= 8'h00;
      wr_dat_reg   <= 8'h00;
    end
    else
    begin
      state_reg    <= state_next;
      bitcnt_reg   <= bitcnt_next;
      idx_reg      <= idx_next;
      shift_reg    <= shift_next;
      tx_reg       <= tx_next;
      rw_reg       <= rw_next;
      ara_reg      <= ara_next;
      ptr_reg      <= ptr_next;
      regs_reg     <= regs_next;
      hold_reg     <= hold_next;
      hold_cnt_reg <= hold_cnt_next;
      sda_oe_n_reg <= sda_oe_n_next;
      done_reg     <= done_next;
      wr_stb_reg   <= wr_stb_next;
      wr_idx_reg   <= wr_idx_next;
      wr_dat_reg   <= wr_dat_next;
    end
  end

  // Outputs
  assign bus.dev_sda_o    = 1'b0;
  assign bus.dev_sda_oe_n = sda_oe_n_reg;
  assign alert_done       = done_reg;
  assign wr_strobe        = wr_stb_reg;
  assign wr_index         = wr_idx_reg;
  assign wr_data          = wr_dat_reg;
  assign hold_active      = hold_reg;

endmodule

/* src/smbtr_host.sv */
`timescale 1ns/10ps
module smbtr_host
  import smbtr_pkg::*;
(
  smbtr_if.host                bus,        // Two-wire link
  input  wire logic            clock,      // System clock
  input  wire logic            arst_n,     // Async reset
  input  wire logic            cmd_valid,  // Transaction request
  output logic                 cmd_ready,  // Idle, request taken
  input  wire smbtr_kind_type  cmd_kind,   // Transaction kind
  input  wire logic [6:0]      cmd_addr,   // Slave address
  input  wire logic [7:0]      cmd_code,   // Command byte
  input  wire logic [7:0]      cmd_data,   // Write data
  output logic                 rsp_valid,  // Transaction done pulse
  output logic [7:0]           rsp_data,   // Read data
  output logic                 rsp_nack    // Slave did not acknowledge
);

  typedef enum logic [1:0] {
    H_IDLE = 2'h1,
    H_RUN  = 2'h2
  } smbtr_host_state_type;

  function automatic smbtr_elem_type elem_of(input smbtr_kind_type k, input logic [2:0] s);
    smbtr_elem_type e;
    e = E_DONE;
    case (s)
      3'h0: e = E_START;
      3'h1: e = (k == KIND_RECV) ? E_RADDR : E_WADDR;
      3'h2: e = (k == KIND_RECV) ? E_READ : E_WCMD;
      3'h3: e = (k == KIND_WRITE) ? E_WDATA : (k == KIND_READ) ? E_START : E_STOP;
      3'h4: e = (k == KIND_WRITE) ? E_STOP : (k == KIND_READ) ? E_RADDR : E_DONE;
      3'h5: e = (k == KIND_READ) ? E_READ : E_DONE;
      3'h6: e = (k == KIND_READ) ? E_STOP : E_DONE;
      default: e = E_DONE;
    endcase
    return e;
  endfunction

  // Step of the closing stop per kind
  function automatic logic [2:0] stop_step(input smbtr_kind_type k);
    return (k == KIND_WRITE) ? 3'h4 : (k == KIND_READ) ? 3'h6 : 3'h3;
  endfunction

  smbtr_host_state_type    state_reg, state_next;
  smbtr_kind_type          kind_reg, kind_next;
  logic [6:0]              addr_reg, addr_next;
  logic [7:0]              code_reg, code_next;
  logic [7:0]              data_reg, data_next;
  logic [2:0]              step_reg, step_next;
  logic [3:0]              bit_reg, bit_next;
  logic [1:0]              qtr_reg, qtr_next;
  logic [TICK_CNT_W-1:0]   tick_reg, tick_next;
  logic [7:0]              shift_reg, shift_next;
  logic                    nack_reg, nack_next;
  logic                    scl_reg, scl_next;
  logic                    sda_oe_n_reg, sda_oe_n_next;
  logic                    rsp_reg, rsp_next;
  logic [1:0]              sda_sync_reg, sda_sync_next;
  smbtr_elem_type          elem;
  logic [7:0]              tx_byte;
  logic                    tick, bit_val, is_byte;

  assign elem    = elem_of(kind_reg, step_reg);
  assign tick    = (tick_reg == TICK_CNT_W'(SCL_QUARTER_CYC - 1));
  assign is_byte = (elem != E_START) && (elem != E_STOP) && (elem != E_DONE);
  assign tx_byte = (elem == E_WADDR) ? {addr_reg, 1'b0} :
                   (elem == E_RADDR) ? {addr_reg, 1'b1} :
                   (elem == E_WCMD)  ? code_reg :
                   (elem == E_WDATA) ? data_reg : 8'hFF;
  assign bit_val = (bit_reg < BYTE_BITS) ? tx_byte[3'h7 - bit_reg[2:0]] : 1'b1;

  // Sequencer and clock divider
  always_comb
  begin
    state_next    = state_reg;
    kind_next     = kind_reg;
    addr_next     = addr_reg;
    code_next     = code_reg;
    data_next     = data_reg;
    step_next     = step_reg;
    bit_next      = bit_reg;
    qtr_next      = qtr_reg;
    tick_next     = tick_reg;
    shift_next    = shift_reg;
    nack_next     = nack_reg;
    rsp_next      = 1'b0;
    sda_sync_next = {sda_sync_reg[0], bus.sda};
    scl_next      = 1'b1;
    sda_oe_n_next = 1'b1;
    case (state_reg)
      H_IDLE:
      begin
        if (cmd_valid)
        begin
          state_next = H_RUN;
          kind_next  = cmd_kind;
          addr_next  = cmd_addr;
          code_next  = cmd_code;
          data_next  = cmd_data;
          step_next  = 3'h0;
          bit_next   = 4'h0;
          qtr_next   = 2'h0;
          tick_next  = '0;
          nack_next  = 1'b0;
        end
      end
      H_RUN:
      begin
        tick_next = tick ? '0 : tick_reg + 1'b1;
        if (elem == E_DONE)
        begin
          state_next = H_IDLE;
          rsp_next   = 1'b1;
        end
        else if (tick)
        begin
          qtr_next = qtr_reg + 2'h1;
          if ((qtr_reg == 2'h2) && is_byte && (bit_reg < BYTE_BITS))
            shift_next = {shift_reg[6:0], sda_sync_reg[1]};
          if ((qtr_reg == 2'h2) && is_byte && (bit_reg == BYTE_BITS)
              && (elem != E_READ) && sda_sync_reg[1])
            nack_next = 1'b1;
          if (qtr_reg == 2'h3)
          begin
            if (is_byte && (bit_reg < BYTE_BITS))
              bit_next = bit_reg + 4'h1;
            else
            begin
              bit_next  = 4'h0;
              step_next = (nack_reg && is_byte) ? stop_step(kind_reg) : step_reg + 3'h1;
            end
          end
        end
        // Line levels for the current quarter
        scl_next = (qtr_reg == 2'h1) || (qtr_reg == 2'h2);
        case (elem)
          E_START: sda_oe_n_next = (qtr_reg < 2'h2);
          E_STOP:  sda_oe_n_next = (qtr_reg >= 2'h2);
          E_DONE:
          begin
            scl_next      = 1'b1;
            sda_oe_n_next = 1'b1;
          end
          default: sda_oe_n_next = bit_val;
        endcase
      end
      default: state_next = H_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_reg    <= H_IDLE;
      kind_reg     <= KIND_WRITE;
      addr_reg     <= 7'h00;
      code_reg     <= 8'h00;
      data_reg     <= 8'h00;
      step_reg     <= 3'h0;
      bit_reg      <= 4'h0;
      qtr_reg      <= 2'h0;
      tick_reg     <= '0;
      shift_reg    <= 8'h00;
      nack_reg     <= 1'b0;
      scl_reg      <= 1'b1;
      sda_oe_n_reg <= 1'b1;
      rsp_reg      <= 1'b0;
      sda_sync_reg <= 2'h3;
    end
    else
    begin
      state_reg    <= state_next;
      kind_reg     <= kind_next;
      addr_reg     <= addr_next;
      code_reg     <= code_next;
      data_reg     <= data_next;
      step_reg     <= step_next;
      bit_reg      <= bit_next;
      qtr_reg      <= qtr_next;
      tick_reg     <= tick_next;
      shift_reg    <= shift_next;
      nack_reg     <= nack_next;
      scl_reg      <= scl_next;
      sda_oe_n_reg <= sda_oe_n_next;
      rsp_reg      <= rsp_next;
      sda_sync_reg <= sda_sync_next;
    end
  end

  // Outputs
  assign bus.scl           = scl_reg;
  assign bus.host_sda_o    = 1'b0;
  assign bus.host_sda_oe_n = sda_oe_n_reg;
  assign cmd_ready         = (state_reg == H_IDLE);
  assign rsp_valid         = rsp_reg;
  assign rsp_data          = shift_reg;
  assign rsp_nack          = nack_reg;

endmodule

/* tb/smbtr_assertions.sv */
`timescale 1ns/10ps
module smbtr_assertions
(
  input wire logic clock,          // System clock
  input wire logic arst_n,         // Async reset
  input wire logic scl,            // Bus clock
  input wire logic host_sda_oe_n,  // Host pulls data low
  input wire logic dev_sda_oe_n,   // Device pulls data low
  input wire logic sda             // Resolved data line
);
  // All checks share the system clock and its reset
  default clocking @(posedge clock);
  endclocking
  default disable iff (!arst_n);

  a_reset_leaves_idle : assert property (
    $rose(arst_n) |-> scl && host_sda_oe_n && dev_sda_oe_n)
    else $error("Link not idle after reset");
  a_dev_after_fall : assert property (
    $changed(dev_sda_oe_n) |-> !scl && $past(scl, 8))
    else $error("Device moved data away from a clock fall");
  a_scl_high_min : assert property (
    $rose(scl) |-> scl[*8])
    else $error("Bus clock high phase too short");
  a_scl_low_min : assert property (
    $fell(scl) |-> !scl[*8])
    else $error("Bus clock low phase too short");
  a_no_contention : assert property (
    scl && !dev_sda_oe_n |-> host_sda_oe_n)
    else $error("Host drives while device answers");
  a_edge_by_host : assert property (
    scl && $past(scl) && $changed(sda) |-> $changed(host_sda_oe_n))
    else $error("Start or stop not made by host");
  a_setup_at_rise : assert property (
    $rose(scl) |-> $stable(host_sda_oe_n) && $stable(dev_sda_oe_n))
    else $error("Data changed at clock rise");
  a_sda_held_high : assert property (
    $rose(scl) |-> $stable(sda)[*8])
    else $error("Data not held after clock rise");
endmodule

/* tb/smbus_temp_register_access_test.sv */
`timescale 1ns/10ps
module smbus_temp_register_access_test
  import smbtr_pkg::*;
;
  localparam int HOLD = 10000;
  localparam int LIMIT = 70000;
  localparam logic [6:0] DEV = DEV_ADDR_DEFAULT;

  logic           clock = 1'b0;
  logic           arst_n = 1'b0;
  logic           cmd_valid = 1'b0;
  logic           cmd_ready;
  smbtr_kind_type cmd_kind = KIND_READ;
  logic [6:0]     cmd_addr = 7'h00;
  logic [7:0]     cmd_code = 8'h00;
  logic [7:0]     cmd_data = 8'h00;
  logic           rsp_valid;
  logic [7:0]     rsp_data;
  logic           rsp_nack;
  logic           conv_valid = 1'b0;
  logic [2:0]     conv_chan = 3'h0;
  logic [11:0]    conv_temp = 12'h000;
  logic [1:0]     conv_fault = 2'h0;
  logic           wr_strobe;
  logic [7:0]     wr_index;
  logic [7:0]     wr_data;
  logic           hold_active;
  logic           alert_req = 1'b0;
  logic           alert_done;
  logic [9:0]     exp_q[$];
  logic [9:0]     note;
  logic [7:0]     wdat;
  integer         seed = 32'h4216;
  int             bad_count = 0;
  int             n_compared = 0;
  int             cycles = 0;
  int             n_wr = 0;
  int             n_al = 0;
  logic [2:0]     t_ch[4] = '{3'h7, 3'h2, 3'h3, 3'h4};
  logic [11:0]    t_tp[4] = '{12'h640, 12'hF80, 12'h000, 12'h000};
  logic [1:0]     t_fl[4] = '{2'h0, 2'h0, 2'h1, 2'h2};
  logic [7:0]     t_ex[4] = '{8'h7F, 8'h00, 8'hFF, 8'hEE};

  smbtr_if link ();

  smbtr_host smbtr_host_i (.bus(link), .clock(clock), .arst_n(arst_n),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_kind(cmd_kind), .cmd_addr(cmd_addr),
    .cmd_code(cmd_code), .cmd_data(cmd_data), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .rsp_nack(rsp_nack));

  smbtr_dev #(.HOLD_CYC(HOLD)) smbtr_dev_i (.bus(link), .clock(clock), .arst_n(arst_n),
    .conv_valid(conv_valid), .conv_chan(conv_chan), .conv_temp(conv_temp),
    .conv_fault(conv_fault), .alert_req(alert_req), .alert_done(alert_done),
    .wr_strobe(wr_strobe), .wr_index(wr_index), .wr_data(wr_data),
    .hold_active(hold_active));

  smbtr_assertions smbtr_assertions_i (.clock(clock), .arst_n(arst_n), .scl(link.scl),
    .host_sda_oe_n(link.host_sda_oe_n), .dev_sda_oe_n(link.dev_sda_oe_n), .sda(link.sda));

  // Clock, pulse counts mid-cycle away from the launching edge, hang guard
  always #5 clock = ~clock;
  always @(negedge clock)
  begin
    cycles++;
    if (wr_strobe === 1'b1)
      n_wr++;
    if (alert_done === 1'b1)
      n_al++;
    if (cycles == LIMIT)
    begin
      bad_count++;
      test_done();
    end
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic conv(input logic [2:0] ch, input logic [11:0] t, input logic [1:0] f);
    conv_chan = ch;
    conv_temp = t;
    conv_fault = f;
    conv_valid = 1'b1;
    tick(1);
    conv_valid = 1'b0;
  endtask

  // Note {data checked, nack, data}, request, then wait for the answer
  task automatic xact(input smbtr_kind_type k, input logic [6:0] a, input logic [7:0] c,
                      input logic [7:0] d, input logic [9:0] e);
    exp_q.push_back(e);
    cmd_kind = k;
    cmd_addr = a;
    cmd_code = c;
    cmd_data = d;
    cmd_valid = 1'b1;
    tick(1);
    cmd_valid = 1'b0;
    while (rsp_valid !== 1'b1)
      tick(1);
    tick(1);
  endtask

  // Oldest note against each finished transfer
  always @(negedge clock)
  begin
    if (rsp_valid === 1'b1 && exp_q.size() > 0)
    begin
      note = exp_q.pop_front();
      check({7'h00, rsp_nack}, {7'h00, note[8]}, "nack");
      if (note[9])
        check(rsp_data, note[7:0], "read data");
    end
  end

  task automatic test_done();
    $display("Compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial
  begin
    tick(4);
    arst_n = 1'b1;
    // Write byte lands in a general register
    wdat = 8'($random(seed));
    xact(KIND_WRITE, DEV, 8'h08, wdat, 10'h000);
    check(wr_index, 8'h08, "write index");
    check(wr_data, wdat, "write data");
    check(8'(n_wr), 8'h01, "write strobes");
    xact(KIND_RECV, DEV, 8'h00, 8'h00, {2'b10, wdat});
    $display("Test write done");
    // Extended byte first, then frozen high byte
    conv(CH1_CHAN, 12'h0C9, 2'h0);
    xact(KIND_READ, DEV, 8'h09, 8'h00, 10'h220);
    check({7'h00, hold_active}, 8'h01, "hold set");
    conv(CH1_CHAN, 12'h190, 2'h0);
    xact(KIND_READ, DEV, 8'h01, 8'h00, 10'h219);
    check({7'h00, hold_active}, 8'h00, "hold cleared");
    $display("Test coherent read done");
    // Clamps and fault codes, then short forms
    for (int i = 0; i < 4; i++)
    begin
      conv(t_ch[i], t_tp[i], t_fl[i]);
      xact(KIND_READ, DEV, {5'h00, t_ch[i]}, 8'h00, {2'b10, t_ex[i]});
    end
    xact(KIND_RECV, DEV, 8'h00, 8'h00, {2'b10, t_ex[3]});
    xact(KIND_WRITE, DEV, REG_LOCAL, 8'hA5, 10'h000);
    check(8'(n_wr), 8'h01, "read-only write ignored");
    xact(KIND_SEND, DEV, 8'h07, 8'h00, 10'h000);
    xact(KIND_RECV, DEV, 8'h00, 8'h00, 10'h27F);
    xact(KIND_RECV, DEV ^ 7'h01, 8'h00, 8'h00, 10'h100);
    alert_req = 1'b1;
    xact(KIND_RECV, ARA_ADDR, 8'h00, 8'h00, {2'b10, DEV, 1'b1});
    alert_req = 1'b0;
    check(8'(n_al), 8'h01, "alert responses");
    $display("Test formats done");
    // Unread high byte releases after the timeout
    xact(KIND_READ, DEV, 8'h09, 8'h00, 10'h220);
    tick(HOLD - 3000);
    check({7'h00, hold_active}, 8'h01, "hold kept");
    tick(3000);
    check({7'h00, hold_active}, 8'h00, "hold released");
    check(8'(exp_q.size()), 8'h00, "missing answers");
    $display("Test timeout done");
    test_done();
  end
endmodule
